/* File: dca_mem_model.sv */
// Memory partner model answering the DMA element mover
`timescale 1ns/100ps
module dca_mem_model
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        slow,        // Wait state every other cycle
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    output logic      [15:0] mem_rdata,
    output logic             mem_ready,
    output logic      [15:0] last_waddr,
    output logic      [15:0] last_wdata,
    output logic      [7:0]  wr_cnt
);
    logic tick_reg;  // Wait-state phase
    always_ff @(posedge sys_clk)
        tick_reg <= srst ? 1'b0 : ~tick_reg;
    assign mem_ready = mem_req & (~slow | tick_reg);
    // Data valid only while answering, inverse otherwise, so a stale sample shows
    assign mem_rdata = mem_ready ? mem_addr ^ 16'hA5A5 : mem_addr ^ 16'h5A5A;
    // Log writes so the bench sees the write half of each element
    always_ff @(posedge sys_clk)
        if (srst)
            wr_cnt <= 8'h00;
        else if (mem_ready & mem_we)
        begin
            last_waddr <= mem_addr;
            last_wdata <= mem_wdata;
            wr_cnt     <= wr_cnt + 8'h01;
        end
endmodule // dca_mem_model

/* File: dca_pkg.sv */
// Constants, register map and state encoding for the DMA channel arbiter
//------------------------------------------------------------------------
// Function
// - High-priority pending channels always served before low
// - Same-level channels granted in round-robin order
// - Priority bits 8..13, one per channel, 1=high
// - Debug halt pauses transfers unless run-on-halt set
// - Each element reads source then writes destination
// - Address registers hold low 16 address bits
// - Addresses advance per element, readable any time
// - CPU address writes take effect at once, even mid-element
// - Element count decrements after each element outside autobuffer mode, reloads at zero
// - Shadow copy reloads element count each frame
// - Autobuffer mode never decrements element count
// - CPU write beats controller update on count
// - Bits 15..12 choose the sync event
// - Bit 11 selects 32-bit elements when set
// - Reserved bits 10..8 ignore writes, read zero
// - Bits 7..0 hold the frame count
// - Block end clears enable; controller beats CPU
// - Frame count decrements per frame; CPU wins
// - Selector zero runs free; else one event, one element
//------------------------------------------------------------------------
package dca_pkg;

    // Channel count and widths
    localparam int CH_NUM = 6;
    localparam int AW     = 8;
    localparam int DW     = 16;

    // Register offsets on the CPU port
    localparam logic [7:0] ADDR_GLOBAL  = 8'h00;   // Enables, priorities, run-on-halt
    localparam logic [7:0] ADDR_ABU     = 8'h01;   // Autobuffer mode per channel
    localparam logic [7:0] ADDR_CH_BASE = 8'h10;   // First channel context word
    localparam logic [1:0] OFS_SRC      = 2'h0;
    localparam logic [1:0] OFS_DST      = 2'h1;
    localparam logic [1:0] OFS_CNT      = 2'h2;
    localparam logic [1:0] OFS_SFC      = 2'h3;

    // Global control field positions
    localparam int EN_LSB   = 0;
    localparam int PRIO_LSB = 8;
    localparam int FREE_BIT = 15;

    // Sync and frame register fields
    localparam int SYNC_MSB  = 15;
    localparam int SYNC_LSB  = 12;
    localparam int WIDE_BIT  = 11;
    localparam int FRAME_MSB = 7;
    localparam logic [15:0] SFC_WMASK = 16'hF8FF;   // Reserved 10..8 dropped
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [3:0]  SYNC_NONE = 4'h0;

    // Address steps per element
    localparam logic [15:0] STEP_NARROW = 16'h0001;
    localparam logic [15:0] STEP_WIDE   = 16'h0002;

    // Transfer sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_READ  = 3'b010,
        ST_WRITE = 3'b100
    } dca_state_t;

endpackage

/* File: dca_top.sv */
// Six-channel DMA engine: arbiter, channel contexts and element mover
//
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/100ps

module dca_top
(
    input  wire logic        sys_clk,       // 100 MHz
    input  wire logic        srst,          // Synchronous, high
    input  wire logic [7:0]  reg_addr,      // CPU register address
    input  wire logic [15:0] reg_wdata,     // CPU write data
    input  wire logic        reg_wr,        // CPU write strobe
    input  wire logic        reg_rd,        // CPU read strobe
    output logic      [15:0] reg_rdata,     // Read data, cycle after strobe
    input  wire logic        halt_in,       // Debug halt pin
    input  wire logic [15:1] sync_evt_in,   // Sync event pins, 1..15
    output logic             mem_req,       // Memory access request
    output logic             mem_we,        // 1 = write, 0 = read
    output logic      [15:0] mem_addr,      // Word address
    output logic      [15:0] mem_wdata,     // Write data
    input  wire logic [15:0] mem_rdata,     // Read data, valid with ready
    input  wire logic        mem_ready      // Access completes this cycle
);

    //--------------------------------------------------------------------
    // Declarations
    //--------------------------------------------------------------------
    localparam int CH = dca_pkg::CH_NUM;

    dca_pkg::dca_state_t state_reg;                  // Sequencer state
    logic [CH-1:0]  en_reg;                          // Channel enables
    logic [CH-1:0]  prio_reg;                        // 1 = high level
    logic           free_reg;                        // Run on halt
    logic [CH-1:0]  abu_reg;                         // Autobuffer mode
    logic [15:0]    src_reg    [CH];                 // Source address
    logic [15:0]    dst_reg    [CH];                 // Destination address
    logic [15:0]    cnt_reg    [CH];                 // Live element counter
    logic [15:0]    shadow_reg [CH];                 // Programmed count
    logic [15:0]    sfc_reg    [CH];                 // Sync, width, frames
    logic [CH-1:0]  pend_reg;                        // Element requested
    logic [CH-1:0]  block_done;                      // Last element of block
    logic [2:0]     gch_reg;                         // Granted channel
    logic           gprio_reg;                       // Level of grant
    logic           half_reg;                        // Second word of pair
    logic [15:0]    data_reg;                        // Word in flight
    logic [2:0]     hi_last_reg;                     // High-level pointer
    logic [2:0]     lo_last_reg;                     // Low-level pointer
    logic           halt_s1;                         // Halt synchroniser
    logic           halt_s2;
    logic [15:1]    evt_s1;                          // Event synchroniser
    logic [15:1]    evt_s2;
    logic [15:1]    evt_q;                           // Edge detect history
    logic [15:0]    evt_rise;                        // Bit 0 unused
    logic [CH-1:0]  hi_req;
    logic [CH-1:0]  lo_req;
    logic [2:0]     pick;                            // Arbiter winner
    logic           grant_go;                        // Start an element
    logic           elem_done;                       // Element complete
    logic           ch_hit;                          // Address in context
    logic [7:0]     ch_off;
    logic [2:0]     ch_idx;
    logic [1:0]     ch_fld;
    logic           wr_glob;
    logic           wr_abu;
    logic [CH-1:0]  wr_src;
    logic [CH-1:0]  wr_dst;
    logic [CH-1:0]  wr_cnt;
    logic [CH-1:0]  wr_sfc;
    logic [CH-1:0]  en_next;
    logic [2:0]     lo_nxt;                          // Checker helper

    //--------------------------------------------------------------------
    // Round-robin search
    //--------------------------------------------------------------------
    // First requester after the last served one, wrapping over six
    function automatic logic [2:0] rr_pick(input logic [5:0] req,
                                           input logic [2:0] last);
        logic [2:0] idx;
        logic       found;
        begin
            rr_pick = last;
            found   = 1'b0;
            for (int i = 1; i <= 6; i++)
            begin
                idx = 3'((int'(last) + i) % 6);
                if (!found && req[idx])
                begin
                    rr_pick = idx;
                    found   = 1'b1;
                end
            end
        end
    endfunction

    //--------------------------------------------------------------------
    // Input synchronisers
    //--------------------------------------------------------------------
    // Pins are asynchronous; only the second stage is looked at
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            halt_s1 <= 1'b0;
            halt_s2 <= 1'b0;
            evt_s1  <= '0;
            evt_s2  <= '0;
            evt_q   <= '0;
        end
        else
        begin
            halt_s1 <= halt_in;
            halt_s2 <= halt_s1;
            evt_s1  <= sync_evt_in;
            evt_s2  <= evt_s1;
            evt_q   <= evt_s2;
        end
    end

    // One event is one rising edge
    assign evt_rise = {evt_s2 & ~evt_q, 1'b0};

    //--------------------------------------------------------------------
    // Register decode
    //--------------------------------------------------------------------
    assign ch_off  = reg_addr - dca_pkg::ADDR_CH_BASE;
    assign ch_idx  = ch_off[4:2];
    assign ch_fld  = ch_off[1:0];
    assign ch_hit  = (reg_addr >= dca_pkg::ADDR_CH_BASE) && (ch_off[7:5] == 3'h0)
                     && (ch_idx < 3'(CH));
    assign wr_glob = reg_wr && (reg_addr == dca_pkg::ADDR_GLOBAL);
    assign wr_abu  = reg_wr && (reg_addr == dca_pkg::ADDR_ABU);

    //--------------------------------------------------------------------
    // Arbitration
    //--------------------------------------------------------------------
    assign hi_req = pend_reg & en_reg & prio_reg;
    assign lo_req = pend_reg & en_reg & ~prio_reg;
    // Low level only sees a grant when no high channel waits
    assign pick   = (|hi_req) ? rr_pick(hi_req, hi_last_reg)
                              : rr_pick(lo_req, lo_last_reg);
    // A halt without run-on-halt holds off new elements only;
    // a pair already under way finishes so memory stays consistent
    assign grant_go  = (state_reg == dca_pkg::ST_IDLE) && (|(hi_req | lo_req))
                       && !(halt_s2 && !free_reg);
    assign elem_done = (state_reg == dca_pkg::ST_WRITE) && mem_ready
                       && (half_reg || !sfc_reg[gch_reg][dca_pkg::WIDE_BIT]);
    assign lo_nxt    = 3'((int'(lo_last_reg) + 1) % 6);

    //--------------------------------------------------------------------
    // Global control register
    //--------------------------------------------------------------------
    // Block completion clears an enable even against a CPU write
    always_comb
    begin
        en_next = wr_glob ? reg_wdata[dca_pkg::EN_LSB +: CH] : en_reg;
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            en_reg   <= '0;
            prio_reg <= '0;
            free_reg <= 1'b0;
            abu_reg  <= '0;
        end
        else
        begin
            en_reg <= en_next & ~block_done;
            if (wr_glob)
            begin
                prio_reg <= reg_wdata[dca_pkg::PRIO_LSB +: CH];
                free_reg <= reg_wdata[dca_pkg::FREE_BIT];
            end
            if (wr_abu)
            begin
                abu_reg <= reg_wdata[CH-1:0];
            end
        end
    end

    //--------------------------------------------------------------------
    // Per-channel context
    //--------------------------------------------------------------------
    for (genvar c = 0; c < CH; c++)
    begin : g_ch
        logic        done_c;                          // Element of c done
        logic        frame_end;                       // Counter at zero
        logic [15:0] step;
        logic [3:0]  sel;

        assign wr_src[c] = reg_wr && ch_hit && (ch_idx == 3'(c))
                           && (ch_fld == dca_pkg::OFS_SRC);
        assign wr_dst[c] = reg_wr && ch_hit && (ch_idx == 3'(c))
                           && (ch_fld == dca_pkg::OFS_DST);
        assign wr_cnt[c] = reg_wr && ch_hit && (ch_idx == 3'(c))
                           && (ch_fld == dca_pkg::OFS_CNT);
        assign wr_sfc[c] = reg_wr && ch_hit && (ch_idx == 3'(c))
                           && (ch_fld == dca_pkg::OFS_SFC);
        assign done_c    = elem_done && (gch_reg == 3'(c));
        assign frame_end = (cnt_reg[c] == 16'h0000);
        assign sel       = sfc_reg[c][dca_pkg::SYNC_MSB:dca_pkg::SYNC_LSB];
        assign step      = sfc_reg[c][dca_pkg::WIDE_BIT] ? dca_pkg::STEP_WIDE
                                                         : dca_pkg::STEP_NARROW;
        // Autobuffer channels circulate and never end a block
        assign block_done[c] = done_c && !abu_reg[c] && frame_end
                               && (sfc_reg[c][dca_pkg::FRAME_MSB:0] == 8'h00);

        // Addresses: CPU write wins and steers the next word at once
        always_ff @(posedge sys_clk)
        begin
            if (srst)
            begin
                src_reg[c] <= dca_pkg::REG_RESET;
                dst_reg[c] <= dca_pkg::REG_RESET;
            end
            else
            begin
                if (wr_src[c])
                    src_reg[c] <= reg_wdata;
                else if (done_c)
                    src_reg[c] <= src_reg[c] + step;
                if (wr_dst[c])
                    dst_reg[c] <= reg_wdata;
                else if (done_c)
                    dst_reg[c] <= dst_reg[c] + step;
            end
        end

        // Element counter with shadow reload
        always_ff @(posedge sys_clk)
        begin
            if (srst)
            begin
                cnt_reg[c]    <= dca_pkg::REG_RESET;
                shadow_reg[c] <= dca_pkg::REG_RESET;
            end
            else if (wr_cnt[c])
            begin
                cnt_reg[c]    <= reg_wdata;
                shadow_reg[c] <= reg_wdata;
            end
            else if (done_c && !abu_reg[c])
            begin
                if (frame_end)
                    cnt_reg[c] <= shadow_reg[c];
                else
                    cnt_reg[c] <= cnt_reg[c] - 16'h0001;
            end
        end

        // Sync, width and frame count; reserved bits never stored
        always_ff @(posedge sys_clk)
        begin
            if (srst)
                sfc_reg[c] <= dca_pkg::REG_RESET;
            else if (wr_sfc[c])
                sfc_reg[c] <= reg_wdata & dca_pkg::SFC_WMASK;
            else if (done_c && !abu_reg[c] && frame_end
                     && (sfc_reg[c][dca_pkg::FRAME_MSB:0] != 8'h00))
                sfc_reg[c][dca_pkg::FRAME_MSB:0] <=
                    sfc_reg[c][dca_pkg::FRAME_MSB:0] - 8'h01;
        end

        // Request flag: a new event in the grant cycle is kept
        always_ff @(posedge sys_clk)
        begin
            if (srst || !en_reg[c])
                pend_reg[c] <= 1'b0;
            else if ((sel == dca_pkg::SYNC_NONE) || evt_rise[sel])
                pend_reg[c] <= 1'b1;
            else if (grant_go && (pick == 3'(c)))
                pend_reg[c] <= 1'b0;
        end
    end

    //--------------------------------------------------------------------
    // Element sequencer
    //--------------------------------------------------------------------
    // Read then write; wide elements repeat with the address LSB flipped
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_reg <= dca_pkg::ST_IDLE;
            gch_reg   <= 3'h0;
            gprio_reg <= 1'b0;
            half_reg  <= 1'b0;
            data_reg  <= 16'h0000;
        end
        else
        begin
            unique case (state_reg)
                dca_pkg::ST_IDLE:
                begin
                    if (grant_go)
                    begin
                        gch_reg   <= pick;
                        gprio_reg <= prio_reg[pick];
                        half_reg  <= 1'b0;
                        state_reg <= dca_pkg::ST_READ;
                    end
                end
                dca_pkg::ST_READ:
                begin
                    if (mem_ready)
                    begin
                        data_reg  <= mem_rdata;
                        state_reg <= dca_pkg::ST_WRITE;
                    end
                end
                dca_pkg::ST_WRITE:
                begin
                    if (mem_ready)
                    begin
                        if (sfc_reg[gch_reg][dca_pkg::WIDE_BIT] && !half_reg)
                        begin
                            half_reg  <= 1'b1;
                            state_reg <= dca_pkg::ST_READ;
                        end
                        else
                            state_reg <= dca_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Pointer moves only when an element really finished
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            hi_last_reg <= 3'h5;
            lo_last_reg <= 3'h5;
        end
        else if (elem_done)
        begin
            if (gprio_reg)
                hi_last_reg <= gch_reg;
            else
                lo_last_reg <= gch_reg;
        end
    end

    //--------------------------------------------------------------------
    // Memory port
    //--------------------------------------------------------------------
    assign mem_req   = (state_reg != dca_pkg::ST_IDLE);
    assign mem_we    = (state_reg == dca_pkg::ST_WRITE);
    assign mem_addr  = mem_we ? (dst_reg[gch_reg] ^ {15'h0000, half_reg})
                              : (src_reg[gch_reg] ^ {15'h0000, half_reg});
    assign mem_wdata = data_reg;

    //--------------------------------------------------------------------
    // Register read port
    //--------------------------------------------------------------------
    // Unmapped addresses answer zero
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            reg_rdata <= 16'h0000;
        else if (reg_rd)
        begin
            reg_rdata <= 16'h0000;
            if (reg_addr == dca_pkg::ADDR_GLOBAL)
                reg_rdata <= {free_reg, 1'b0, prio_reg, 2'b00, en_reg};
            else if (reg_addr == dca_pkg::ADDR_ABU)
                reg_rdata <= {10'h000, abu_reg};
            else if (ch_hit)
            begin
                unique case (ch_fld)
                    dca_pkg::OFS_SRC: reg_rdata <= src_reg[ch_idx];
                    dca_pkg::OFS_DST: reg_rdata <= dst_reg[ch_idx];
                    dca_pkg::OFS_CNT: reg_rdata <= cnt_reg[ch_idx];
                    dca_pkg::OFS_SFC: reg_rdata <= sfc_reg[ch_idx];
                endcase
            end
        end
    end

    //--------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------
    property p_hi_first;
        @(posedge sys_clk) disable iff (srst)
        grant_go && (|hi_req) |=> gprio_reg && prio_reg[gch_reg];
    endproperty
    a_hi_first: assert property (p_hi_first) else $error("low granted over high");

    property p_rr_next;
        @(posedge sys_clk) disable iff (srst)
        grant_go && !(|hi_req) && lo_req[lo_nxt] |=> (gch_reg == $past(lo_nxt));
    endproperty
    a_rr_next: assert property (p_rr_next) else $error("round robin skipped");

    property p_halt;
        @(posedge sys_clk) disable iff (srst)
        (state_reg == dca_pkg::ST_IDLE) && halt_s2 && !free_reg
        |=> (state_reg == dca_pkg::ST_IDLE);
    endproperty
    a_halt: assert property (p_halt) else $error("transfer started in halt");

    property p_rd_wr;
        @(posedge sys_clk) disable iff (srst)
        (state_reg == dca_pkg::ST_READ) && mem_ready
        |=> mem_we && (mem_wdata == $past(mem_rdata));
    endproperty
    a_rd_wr: assert property (p_rd_wr) else $error("write did not follow read");

    property p_src_step;
        @(posedge sys_clk) disable iff (srst)
        elem_done && (gch_reg == 3'h0) && !wr_src[0] && !sfc_reg[0][dca_pkg::WIDE_BIT]
        |=> (src_reg[0] == $past(src_reg[0]) + 16'h0001);
    endproperty
    a_src_step: assert property (p_src_step) else $error("source not advanced");

    property p_cnt_cpu;
        @(posedge sys_clk) disable iff (srst)
        wr_cnt[0] |=> (cnt_reg[0] == $past(reg_wdata)) && (shadow_reg[0] == cnt_reg[0]);
    endproperty
    a_cnt_cpu: assert property (p_cnt_cpu) else $error("count write lost");

    property p_abu_hold;
        @(posedge sys_clk) disable iff (srst)
        abu_reg[0] && !wr_cnt[0] && !wr_abu |=> $stable(cnt_reg[0]);
    endproperty
    a_abu_hold: assert property (p_abu_hold) else $error("autobuffer count moved");

    property p_rsvd;
        @(posedge sys_clk) disable iff (srst)
        wr_sfc[0] |=> (sfc_reg[0][10:8] == 3'h0) ##1 (sfc_reg[0][10:8] == 3'h0);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits stored");

    property p_en_clear;
        @(posedge sys_clk) disable iff (srst)
        block_done[0] |=> !en_reg[0] && !mem_req;
    endproperty
    a_en_clear: assert property (p_en_clear) else $error("enable kept at block end");

endmodule // dca_top

/* File: dca_top_tb.sv */
// Self-checking bench for the six-channel DMA engine
`timescale 1ns/100ps
module dca_top_tb;
    logic        sys_clk, srst, reg_wr, reg_rd, halt_in, slow, mem_req, mem_we, mem_ready;
    logic [7:0]  reg_addr, wr_cnt, n0;
    logic [15:1] evt;  // Sync event pins
    logic [15:0] reg_wdata, reg_rdata, mem_addr, mem_wdata, mem_rdata, lwa, lwd, q;
    int          fails = 0, tests_run = 0, cyc = 0;
    // Register rows: address, written value, value read back
    logic [7:0]  ra [5] = '{8'h13, 8'h10, 8'h01, 8'h00, 8'h05};
    logic [15:0] rw [5] = '{16'hFFFF, 16'h1234, 16'h003F, 16'h3F00, 16'hFFFF};
    logic [15:0] re [5] = '{16'hF8FF, 16'h1234, 16'h003F, 16'h3F00, 16'h0000};
    dca_top i_dut (.sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .halt_in(halt_in),
        .sync_evt_in(evt), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ready(mem_ready));
    dca_mem_model i_mem (.sys_clk(sys_clk), .srst(srst), .slow(slow), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
        .mem_ready(mem_ready), .last_waddr(lwa), .last_wdata(lwd), .wr_cnt(wr_cnt));
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // Poll until every enable bit has been cleared by block end
    task automatic done();
        rd(8'h00);
        repeat (200) if (q[5:0] !== 6'h00) rd(8'h00);
        chk("enable", 16'h0000, {10'h000, q[5:0]});
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            close_out();
        end
    end
    initial
    begin
        {srst, reg_wr, reg_rd, halt_in, slow} = 5'b10000;
        reg_addr  = 8'h00;
        reg_wdata = 16'h0000;
        evt       = 15'h0000;
        repeat (12) @(posedge sys_clk);
        srst <= 1'b0;
        rd(8'h13);
        chk("sfc_reset", 16'h0000, q);
        foreach (ra[i])
        begin
            wr(ra[i], rw[i]);
            rd(ra[i]);
            chk("reg_row", re[i], q);
        end
        // Two frames of two elements on channel 0, slow memory
        slow <= 1'b1;
        n0 = wr_cnt;
        wr(8'h01, 16'h0000); wr(8'h10, 16'h0100); wr(8'h11, 16'h0200);
        wr(8'h12, 16'h0001); wr(8'h13, 16'h0001); wr(8'h00, 16'h0001);
        done();
        chk("writes", 16'h0004, {8'h00, wr_cnt - n0});
        chk("dst", 16'h0203, lwa);
        chk("data", 16'hA4A6, lwd);
        rd(8'h10);
        chk("src", 16'h0104, q);
        rd(8'h00);
        chk("global", 16'h0000, q);
        // High channel 2 beats low channel 1 raised in the same write
        wr(8'h15, 16'h1000); wr(8'h16, 16'h0000); wr(8'h17, 16'h0000);
        wr(8'h19, 16'h2000); wr(8'h1A, 16'h0000); wr(8'h1B, 16'h0000);
        n0 = wr_cnt;
        wr(8'h00, 16'h0406);
        repeat (100) if (wr_cnt == n0) @(posedge sys_clk);
        chk("first", 16'h2000, lwa);
        done();
        chk("second", 16'h1000, lwa);
        // Halt holds transfers until run-on-halt is set
        halt_in <= 1'b1;
        wr(8'h12, 16'h0000); wr(8'h13, 16'h0000);
        n0 = wr_cnt;
        wr(8'h00, 16'h0001);
        repeat (30) @(posedge sys_clk);
        chk("halted", {8'h00, n0}, {8'h00, wr_cnt});
        wr(8'h00, 16'h8001);
        done();
        chk("free", 16'h0001, {8'h00, wr_cnt - n0});
        // One sync event moves one wide element: two word pairs
        wr(8'h10, 16'h0300); wr(8'h11, 16'h0400); wr(8'h12, 16'h0000);
        wr(8'h13, 16'h1800);
        n0 = wr_cnt;
        wr(8'h00, 16'h8001);
        repeat (20) @(posedge sys_clk);
        chk("no_event", {8'h00, n0}, {8'h00, wr_cnt});
        evt <= 15'h0001;
        repeat (4) @(posedge sys_clk);
        evt <= 15'h0000;
        done();
        chk("wide_writes", 16'h0002, {8'h00, wr_cnt - n0});
        chk("wide_dst", 16'h0401, lwa);
        chk("wide_data", 16'hA6A4, lwd);
        close_out();
    end
endmodule // dca_top_tb
